// ---- rtl/ppe_config_regs.sv ----
// Configuration registers and control logic
`timescale 1ns/1ps
module ppe_config_regs #(
    parameter int TICK_CYCLES = ppe_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              srst,
    // Register access port
    input  wire logic              regWrStb,
    input  wire logic              regRdStb,
    input  wire logic [7:0]        regAddr,
    input  wire logic [7:0]        regWrData,
    output logic [7:0]             regRdData,
    // Device state
    input  wire ppe_pkg::ppe_emu_t emuStatus,
    input  wire ppe_pkg::ppe_pwr_t powerState,
    input  wire logic              attachDetectEnable,
    input  wire logic              sleepEnter,
    input  wire logic [2:0]        limitSetResistorCode,
    // Charge rationing
    input  wire logic [15:0]       chargeTotal,
    input  wire logic              chargeTotalUpdate,
    input  wire logic              reachedClear,
    input  wire logic [1:0]        rationActionSel,
    output logic                   reachedFlagA,
    output logic                   rationActionStb,
    output logic [1:0]             rationActionOut,
    // Fault handling
    input  wire logic              latchFaultMode,
    input  wire logic              errorEnter,
    input  wire logic              errorClear,
    input  wire logic              overTemp,
    input  wire logic              backDrive,
    input  wire logic              vbusBelowTestPin,
    output ppe_pkg::ppe_rec_t      recovery,
    // Configuration outputs
    output logic                   dataSwitchClose,
    output logic [2:0]             currentLimitSel,
    output logic [1:0]             testVoltageSel,
    output logic [3:0]             emulationSuccessCurrent
);
    import ppe_pkg::*;

    // Auto-recovery states
    typedef enum logic [2:0] {
        REC_IDLE    = 3'b000,
        REC_LATCHED = 3'b001,
        REC_WAIT    = 3'b010,
        REC_CHECK   = 3'b011,
        REC_TEST    = 3'b100
    } ppe_rec_state_t;

    // Registers
    logic [7:0]     switchCfg_ff;
    logic [2:0]     curLimit_ff;
    logic [7:0]     thrHigh_ff;
    logic [7:0]     thrLow_ff;
    logic [6:0]     recCfg_ff;
    logic [3:0]     successCur_ff;
    logic [2:0]     hwLimit_ff;
    logic           loadDefault_ff;
    logic           custLatched_ff;
    logic           cdpLatched_ff;
    logic           restartHold_ff;
    logic           vbusSync1_ff;
    logic           vbusSync2_ff;
    ppe_rec_state_t recState_ff;
    ppe_rec_state_t nxt_recState;
    logic [7:0]     msCount_ff;
    logic [7:0]     nxt_msCount;
    logic           nxt_switch;
    logic           msTick;
    logic           rationHit;
    logic [2:0]     retryDelaySel;
    logic [1:0]     testPeriodSel;
    logic [7:0]     retryDelayMs;
    logic [7:0]     testPeriodMs;
    logic [7:0]     wrMasked;
    logic           wrSwitch;
    logic           wrLimit;
    logic           wrHigh;
    logic           wrLow;
    logic           wrRec;
    logic           wrSuccess;

    // Base plus code times 5 ms
    function automatic logic [7:0] step_ms(input logic [7:0] base, input logic [2:0] code);
        step_ms = base + 8'(code * STEP_MS);
    endfunction

    // Lower of two limit codes
    function automatic logic [2:0] min_code(input logic [2:0] a, input logic [2:0] b);
        min_code = (a < b) ? a : b;
    endfunction

    // Write strobes per register
    assign wrMasked  = regWrData;
    assign wrSwitch  = regWrStb && (regAddr == ADDR_SWITCH_CFG);
    assign wrLimit   = regWrStb && (regAddr == ADDR_CUR_LIMIT);
    assign wrHigh    = regWrStb && (regAddr == ADDR_THR_HIGH);
    assign wrLow     = regWrStb && (regAddr == ADDR_THR_LOW);
    assign wrRec     = regWrStb && (regAddr == ADDR_RECOVERY);
    assign wrSuccess = regWrStb && (regAddr == ADDR_SUCCESS_CUR);

    // Millisecond tick
    ppe_tick_div #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .mclk   (mclk),
        .srst   (srst),
        .msTick (msTick)
    );

    // Switch configuration, kept in Sleep
    always_ff @(posedge mclk) begin
        if (srst) begin
            switchCfg_ff <= RST_SWITCH_CFG;
        end else if (wrSwitch) begin
            switchCfg_ff <= wrMasked & MASK_SWITCH_CFG;
        end
    end

    // Capture resistor limit after reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            loadDefault_ff <= 1'b1;
            hwLimit_ff     <= 3'h0;
        end else if (loadDefault_ff) begin
            loadDefault_ff <= 1'b0;
            hwLimit_ff     <= limitSetResistorCode;
        end
    end

    // Current limit, clamped to resistor value
    always_ff @(posedge mclk) begin
        if (srst) begin
            curLimit_ff <= RST_CUR_LIMIT[2:0];
        end else if (loadDefault_ff) begin
            curLimit_ff <= limitSetResistorCode;
        end else if (wrLimit) begin
            curLimit_ff <= min_code(wrMasked[2:0], hwLimit_ff);
        end
    end

    // Rationing threshold bytes, all ones at reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            thrHigh_ff <= RST_THR_BYTE;
            thrLow_ff  <= RST_THR_BYTE;
        end else begin
            if (wrHigh) begin
                thrHigh_ff <= wrMasked;
            end
            if (wrLow) begin
                thrLow_ff <= wrMasked;
            end
        end
    end

    // Recovery configuration, kept in Sleep
    always_ff @(posedge mclk) begin
        if (srst) begin
            recCfg_ff <= RST_RECOVERY[6:0];
        end else if (wrRec) begin
            recCfg_ff <= wrMasked[6:0] & MASK_RECOVERY[6:0];
        end
    end

    // Success threshold, default again on Sleep
    always_ff @(posedge mclk) begin
        if (srst) begin
            successCur_ff <= RST_SUCCESS_CUR[3:0];
        end else if (sleepEnter) begin
            successCur_ff <= RST_SUCCESS_CUR[3:0];
        end else if (wrSuccess) begin
            successCur_ff <= wrMasked[3:0] & MASK_SUCCESS_CUR[3:0];
        end
    end

    // Read data; unmapped offsets read zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            regRdData <= 8'h00;
        end else if (regRdStb) begin
            case (regAddr)
                ADDR_SWITCH_CFG:  regRdData <= switchCfg_ff;
                ADDR_CUR_LIMIT:   regRdData <= {5'h00, curLimit_ff};
                ADDR_THR_HIGH:    regRdData <= thrHigh_ff;
                ADDR_THR_LOW:     regRdData <= thrLow_ff;
                ADDR_RECOVERY:    regRdData <= {1'b0, recCfg_ff};
                ADDR_SUCCESS_CUR: regRdData <= {4'h0, successCur_ff};
                default:          regRdData <= 8'h00;
            endcase
        end
    end

    // Profile switch bits frozen at emulation start
    always_ff @(posedge mclk) begin
        if (srst) begin
            custLatched_ff <= RST_SWITCH_CFG[SW_CUST_BIT];
            cdpLatched_ff  <= RST_SWITCH_CFG[SW_CDP_BIT];
        end else if (emuStatus.start || emuStatus.restart) begin
            custLatched_ff <= switchCfg_ff[SW_CUST_BIT];
            cdpLatched_ff  <= switchCfg_ff[SW_CDP_BIT];
        end
    end

    // Restart holds switch closed until a profile
    always_ff @(posedge mclk) begin
        if (srst) begin
            restartHold_ff <= 1'b0;
        end else if (emuStatus.restart) begin
            restartHold_ff <= 1'b1;
        end else if (emuStatus.applied != PPE_PROF_NONE) begin
            restartHold_ff <= 1'b0;
        end
    end

    // Data switch decision
    always_comb begin
        nxt_switch = 1'b0;
        if (emuStatus.restart || restartHold_ff) begin
            nxt_switch = 1'b1;
        end else if (powerState == PPE_PWR_DETECT) begin
            nxt_switch = attachDetectEnable && switchCfg_ff[SW_DET_BIT];
        end else if (emuStatus.active) begin
            case (emuStatus.applied)
                PPE_PROF_CUSTOM: nxt_switch = custLatched_ff;
                PPE_PROF_CDP:    nxt_switch = cdpLatched_ff;
                PPE_PROF_DCPLEG: nxt_switch = 1'b0;
                default:         nxt_switch = 1'b0;
            endcase
        end else if (emuStatus.accepted == PPE_PROF_CUSTOM) begin
            nxt_switch = custLatched_ff;
        end else if (emuStatus.accepted == PPE_PROF_DCPLEG) begin
            nxt_switch = (powerState == PPE_PWR_ACTIVE) && emuStatus.charging
                && switchCfg_ff[SW_DCE_BIT];
        end else begin
            nxt_switch = 1'b0;
        end
    end

    // Registered switch control
    always_ff @(posedge mclk) begin
        if (srst) begin
            dataSwitchClose <= 1'b0;
        end else begin
            dataSwitchClose <= nxt_switch;
        end
    end

    // Two-stage sync of the bus voltage pin
    always_ff @(posedge mclk) begin
        if (srst) begin
            vbusSync1_ff <= 1'b0;
            vbusSync2_ff <= 1'b0;
        end else begin
            vbusSync1_ff <= vbusBelowTestPin;
            vbusSync2_ff <= vbusSync1_ff;
        end
    end

    // Recovery timing fields
    assign retryDelaySel = recCfg_ff[RETRY_LSB +: 3];
    assign testPeriodSel = recCfg_ff[PERIOD_LSB +: 2];
    assign retryDelayMs  = step_ms(RETRY_BASE_MS, retryDelaySel);
    assign testPeriodMs  = step_ms(PERIOD_BASE_MS, {1'b0, testPeriodSel});

    // Auto-recovery sequencer
    always_comb begin
        nxt_recState = recState_ff;
        nxt_msCount  = msCount_ff;
        case (recState_ff)
            REC_IDLE: begin
                if (errorEnter) begin
                    nxt_msCount  = 8'h00;
                    nxt_recState = latchFaultMode ? REC_LATCHED : REC_WAIT;
                end
            end
            REC_LATCHED: begin
                if (errorClear) begin
                    nxt_recState = REC_IDLE;
                end else if (!latchFaultMode) begin
                    nxt_msCount  = 8'h00;
                    nxt_recState = REC_WAIT;
                end
            end
            REC_WAIT: begin
                if (msTick) begin
                    nxt_msCount = msCount_ff + 8'h01;
                end
                if (msTick && (msCount_ff + 8'h01 >= retryDelayMs)) begin
                    nxt_recState = REC_CHECK;
                end
            end
            REC_CHECK: begin
                nxt_msCount = 8'h00;
                if (overTemp || backDrive) begin
                    nxt_recState = REC_WAIT;
                end else begin
                    nxt_recState = REC_TEST;
                end
            end
            REC_TEST: begin
                if (msTick) begin
                    nxt_msCount = msCount_ff + 8'h01;
                end
                if (msTick && (msCount_ff + 8'h01 >= testPeriodMs)) begin
                    nxt_msCount  = 8'h00;
                    nxt_recState = vbusSync2_ff ? REC_WAIT : REC_IDLE;
                end
            end
            default: begin
                nxt_recState = REC_IDLE;
                nxt_msCount  = 8'h00;
            end
        endcase
    end

    // Sequencer state and timer
    always_ff @(posedge mclk) begin
        if (srst) begin
            recState_ff <= REC_IDLE;
            msCount_ff  <= 8'h00;
        end else begin
            recState_ff <= nxt_recState;
            msCount_ff  <= nxt_msCount;
        end
    end

    // Recovery outputs
    always_ff @(posedge mclk) begin
        if (srst) begin
            recovery <= '0;
        end else begin
            recovery.portPowerOn    <= (nxt_recState == REC_TEST);
            recovery.useTestCurrent <= (nxt_recState == REC_TEST);
            recovery.testPhase      <= (nxt_recState == REC_TEST);
            recovery.shortDetected  <= (recState_ff == REC_TEST)
                && (nxt_recState == REC_WAIT);
            recovery.recovered      <= (recState_ff == REC_TEST)
                && (nxt_recState == REC_IDLE);
        end
    end

    // Rationing comparator
    ppe_reached_flag_a_check u_reached_flag_a (
        .mclk              (mclk),
        .srst              (srst),
        .chargeTotal       (chargeTotal),
        .chargeTotalUpdate (chargeTotalUpdate),
        .chargeRationLimit ({thrHigh_ff, thrLow_ff}),
        .reachedClear      (reachedClear),
        .reachedFlagA      (reachedFlagA),
        .rationHit         (rationHit)
    );

    // Action strobe after a hit
    always_ff @(posedge mclk) begin
        if (srst) begin
            rationActionStb <= 1'b0;
            rationActionOut <= 2'h0;
        end else begin
            rationActionStb <= rationHit;
            if (rationHit) begin
                rationActionOut <= rationActionSel;
            end
        end
    end

    // Configuration fields out
    always_ff @(posedge mclk) begin
        if (srst) begin
            currentLimitSel         <= RST_CUR_LIMIT[2:0];
            testVoltageSel          <= RST_RECOVERY[1:0];
            emulationSuccessCurrent <= RST_SUCCESS_CUR[3:0];
        end else begin
            currentLimitSel         <= min_code(curLimit_ff, hwLimit_ff);
            testVoltageSel          <= recCfg_ff[VOLT_LSB +: 2];
            emulationSuccessCurrent <= successCur_ff;
        end
    end

endmodule

// ---- rtl/ppe_pkg.sv ----
// Constants and types of the emulation configuration block
// How it works
// - Custom bit keeps switch closed during custom profile
// - Profile switch bits sampled at emulation start or restart only
// - Emulation restart closes the data switch
// - Downstream port bit sets switch during handshake
// - Detect bit drives switch unless attach detection off
// - Post-accept bit closes switch after accepted DCPLEG charging in active state
// - Three-bit code selects port current limit
// - Resistor sets default; writes never exceed it
// - Charge update compared to threshold sets flag
// - Sixteen-bit threshold in two bytes, resets ones
// - Recovery: test current, power on, start timer
// - Low bus voltage at timer end means short
// - Retry delay 15 to 50 ms, 5 ms steps
// - Test period 10 to 25 ms by code
// - Four-bit success current threshold, resets all ones
// - Success threshold restored to default on Sleep
// - Other registers keep contents across Sleep
// - Latch mode clear means automatic retry
package ppe_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_CUR_LIMIT   = 8'h19;
    localparam logic [7:0] ADDR_THR_HIGH    = 8'h1A;
    localparam logic [7:0] ADDR_THR_LOW     = 8'h1B;
    localparam logic [7:0] ADDR_RECOVERY    = 8'h1C;
    localparam logic [7:0] ADDR_SUCCESS_CUR = 8'h1E;
    localparam logic [7:0] ADDR_SWITCH_CFG  = 8'h25;

    // Reset values
    localparam logic [7:0] RST_CUR_LIMIT    = 8'h00;
    localparam logic [7:0] RST_THR_BYTE     = 8'hFF;
    localparam logic [7:0] RST_RECOVERY     = 8'h2A;
    localparam logic [7:0] RST_SUCCESS_CUR  = 8'h0F;
    localparam logic [7:0] RST_SWITCH_CFG   = 8'h14;

    // Field positions and implemented-bit masks
    localparam int         SW_CUST_BIT      = 3;
    localparam int         SW_CDP_BIT       = 2;
    localparam int         SW_DET_BIT       = 1;
    localparam int         SW_DCE_BIT       = 0;
    localparam logic [7:0] MASK_SWITCH_CFG  = 8'h1F;
    localparam logic [7:0] MASK_CUR_LIMIT   = 8'h07;
    localparam logic [7:0] MASK_RECOVERY    = 8'h7F;
    localparam logic [7:0] MASK_SUCCESS_CUR = 8'h0F;
    localparam int         RETRY_LSB        = 4;
    localparam int         PERIOD_LSB       = 2;
    localparam int         VOLT_LSB         = 0;

    // One millisecond at 100 MHz
    localparam int         CLK_PERIOD_NS    = 10;
    localparam int         MS_NS            = 1000000;
    localparam int         MS_CYCLES        = MS_NS / CLK_PERIOD_NS;
    localparam logic [7:0] RETRY_BASE_MS    = 8'h0F;
    localparam logic [7:0] PERIOD_BASE_MS   = 8'h0A;
    localparam logic [7:0] STEP_MS          = 8'h05;

    // Charger emulation profile classes
    typedef enum logic [1:0] {
        PPE_PROF_NONE   = 2'b00,
        PPE_PROF_CUSTOM = 2'b01,
        PPE_PROF_CDP    = 2'b10,
        PPE_PROF_DCPLEG = 2'b11
    } ppe_prof_t;

    // Power states
    typedef enum logic [1:0] {
        PPE_PWR_OTHER  = 2'b00,
        PPE_PWR_DETECT = 2'b01,
        PPE_PWR_ACTIVE = 2'b10
    } ppe_pwr_t;

    // Emulation engine status
    typedef struct packed {
        logic      start;
        logic      restart;
        logic      active;
        ppe_prof_t applied;
        ppe_prof_t accepted;
        logic      charging;
    } ppe_emu_t;

    // Auto-recovery actions
    typedef struct packed {
        logic portPowerOn;
        logic useTestCurrent;
        logic shortDetected;
        logic recovered;
        logic testPhase;
    } ppe_rec_t;

endpackage

// ---- rtl/ppe_tick_div.sv ----
// Millisecond enable divider
`timescale 1ns/1ps
module ppe_tick_div #(
    parameter int TICK_CYCLES = ppe_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // Tick out
    output logic      msTick
);
    import ppe_pkg::*;

    logic [31:0] count_ff;

    // Pulse once per millisecond
    always_ff @(posedge mclk) begin
        if (srst) begin
            count_ff <= 32'h0000_0000;
            msTick   <= 1'b0;
        end else if (count_ff == 32'(TICK_CYCLES - 1)) begin
            count_ff <= 32'h0000_0000;
            msTick   <= 1'b1;
        end else begin
            count_ff <= count_ff + 32'h0000_0001;
            msTick   <= 1'b0;
        end
    end
endmodule

// ---- rtl/ppe_reached_flag_a_check.sv ----
// Rationing comparator with sticky flag
`timescale 1ns/1ps
module ppe_reached_flag_a_check (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // Charge total and threshold
    input  wire logic [15:0] chargeTotal,
    input  wire logic        chargeTotalUpdate,
    input  wire logic [15:0] chargeRationLimit,
    input  wire logic        reachedClear,
    // Results
    output logic             reachedFlagA,
    output logic             rationHit
);
    import ppe_pkg::*;

    logic hit;

    // Compare on each total update
    assign hit = chargeTotalUpdate && (chargeTotal >= chargeRationLimit);

    // Sticky flag, set wins over clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            reachedFlagA <= 1'b0;
            rationHit    <= 1'b0;
        end else begin
            rationHit <= hit;
            if (hit) begin
                reachedFlagA <= 1'b1;
            end else if (reachedClear) begin
                reachedFlagA <= 1'b0;
            end
        end
    end
endmodule

// ---- sim/ppe_config_props.sv ----
// Port checker for the configuration block
`timescale 1ns/1ps
module ppe_config_props (
    // Clock and reset
    input wire logic              mclk,
    input wire logic              srst,
    // Register port
    input wire logic              regRdStb,
    input wire logic [7:0]        regAddr,
    input wire logic [7:0]        regRdData,
    // Device side
    input wire ppe_pkg::ppe_emu_t emuStatus,
    input wire logic              sleepEnter,
    input wire logic [2:0]        limitSetResistorCode,
    input wire logic              chargeTotalUpdate,
    input wire logic              reachedClear,
    input wire logic              reachedFlagA,
    input wire logic              rationActionStb,
    input wire ppe_pkg::ppe_rec_t recovery,
    input wire logic              dataSwitchClose,
    input wire logic [2:0]        currentLimitSel,
    input wire logic [1:0]        testVoltageSel,
    input wire logic [3:0]        emulationSuccessCurrent
);
    import ppe_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    a_reset_vals: assert property ($fell(srst) |-> !dataSwitchClose
        && emulationSuccessCurrent == 4'hF && testVoltageSel == 2'h2) else $error("reset value");
    a_rd_hold: assert property (!regRdStb |=> $stable(regRdData)) else $error("read moved");
    a_unimpl_zero: assert property (regRdStb && regAddr == ADDR_CUR_LIMIT
        |=> regRdData[7:3] == 5'h00) else $error("upper bits set");
    a_limit_clamp: assert property (currentLimitSel <= limitSetResistorCode)
        else $error("limit above hw");
    a_restart_close: assert property (emuStatus.restart |=> dataSwitchClose)
        else $error("restart open");
    a_sleep_default: assert property (sleepEnter |-> ##[1:2]
        emulationSuccessCurrent == 4'hF) else $error("sleep kept value");
    a_action_cause: assert property (rationActionStb |-> $past(chargeTotalUpdate, 2))
        else $error("action without update");
    a_flag_sticky: assert property (reachedFlagA && !reachedClear |=> reachedFlagA)
        else $error("flag dropped");
    a_test_power: assert property (recovery.testPhase |->
        recovery.portPowerOn && recovery.useTestCurrent) else $error("test power");
endmodule
bind ppe_config_regs ppe_config_props u_props (.mclk(mclk), .srst(srst), .regRdStb(regRdStb),
    .regAddr(regAddr), .regRdData(regRdData), .emuStatus(emuStatus), .sleepEnter(sleepEnter),
    .limitSetResistorCode(limitSetResistorCode), .chargeTotalUpdate(chargeTotalUpdate),
    .reachedClear(reachedClear), .reachedFlagA(reachedFlagA), .rationActionStb(rationActionStb),
    .recovery(recovery), .dataSwitchClose(dataSwitchClose), .currentLimitSel(currentLimitSel),
    .testVoltageSel(testVoltageSel), .emulationSuccessCurrent(emulationSuccessCurrent));

// ---- sim/ppe_port_dev.sv ----
// Portable device model: accepts a profile, draws charge
`timescale 1ns/1ps
module ppe_port_dev (
    // Clock and reset
    input wire logic               mclk,
    input wire logic               srst,
    // Bench requests
    input wire logic               beginEmu,
    input wire logic               restartReq,
    input wire ppe_pkg::ppe_prof_t offer,
    // Toward the block
    output ppe_pkg::ppe_emu_t      emu,
    output logic [15:0]            chTot,
    output logic                   chUpd
);
    import ppe_pkg::*;
    logic [3:0] age_ff;
    // Accept 16 cycles after start, then charge
    always_ff @(posedge mclk) begin
        if (srst) begin
            emu <= 8'h00;
            chTot <= 16'h0000;
            chUpd <= 1'h0;
            age_ff <= 4'h0;
        end else begin
            emu.start <= beginEmu;
            emu.restart <= restartReq;
            age_ff <= age_ff + 4'h1;
            chUpd <= emu.charging && age_ff[1:0] == 2'h3;
            if (chUpd) chTot <= chTot + 16'h0010;
            if (beginEmu) begin
                emu.active <= 1'h1;
                emu.applied <= offer;
                emu.accepted <= PPE_PROF_NONE;
                emu.charging <= 1'h0;
                age_ff <= 4'h0;
            end else if (emu.active && age_ff == 4'hF) begin
                emu.active <= 1'h0;
                emu.accepted <= emu.applied;
                emu.charging <= 1'h1;
            end
        end
    end
endmodule

// ---- sim/ppe_config_regs_tb.sv ----
// Bench for the configuration block
`timescale 1ns/1ps
module ppe_config_regs_tb;
    import ppe_pkg::*;
    logic mclk = 1'h0, srst = 1'h1, wrStb = 1'h0, rdStb = 1'h0, sleep = 1'h0, attach = 1'h0;
    logic go = 1'h0, rstrt = 1'h0, errIn = 1'h0, latch = 1'h0, vbus = 1'h0, clr = 1'h0;
    logic [2:0] hwLim = 3'h5;
    logic [7:0] adr = 8'h00, wd = 8'h00, rdata;
    ppe_pwr_t pwr = PPE_PWR_OTHER;
    ppe_prof_t offer = PPE_PROF_NONE;
    ppe_emu_t emu;
    ppe_rec_t rec;
    logic [15:0] chTot;
    logic chUpd, flagA, close;
    logic [2:0] limSel;
    logic [1:0] vSel;
    logic [3:0] succ;
    int n_errors = 0, checks_done = 0, n;
    ppe_config_regs #(.TICK_CYCLES(10)) dut (.mclk(mclk), .srst(srst), .regWrStb(wrStb),
        .regRdStb(rdStb), .regAddr(adr), .regWrData(wd), .regRdData(rdata), .emuStatus(emu),
        .powerState(pwr), .attachDetectEnable(attach), .sleepEnter(sleep),
        .limitSetResistorCode(hwLim), .chargeTotal(chTot), .chargeTotalUpdate(chUpd),
        .reachedClear(clr), .rationActionSel(2'h1), .reachedFlagA(flagA),
        .rationActionStb(), .rationActionOut(), .latchFaultMode(latch), .errorEnter(errIn),
        .errorClear(1'h0), .overTemp(1'h0), .backDrive(1'h0), .vbusBelowTestPin(vbus),
        .recovery(rec), .dataSwitchClose(close), .currentLimitSel(limSel),
        .testVoltageSel(vSel), .emulationSuccessCurrent(succ));
    ppe_port_dev u_dev (.mclk(mclk), .srst(srst), .beginEmu(go), .restartReq(rstrt),
        .offer(offer), .emu(emu), .chTot(chTot), .chUpd(chUpd));
    // Clock
    always #5 mclk = ~mclk;
    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        adr = a;
        wd = d;
        wrStb = 1'h1;
        cyc(1);
        wrStb = 1'h0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        adr = a;
        rdStb = 1'h1;
        cyc(1);
        rdStb = 1'h0;
        chk(rdata, exp);
        cyc(1);
    endtask
    task automatic emulate(input ppe_prof_t p);
        offer = p;
        go = 1'h1;
        cyc(1);
        go = 1'h0;
        cyc(3);
    endtask
    // Reset values and limit clamp
    task automatic t_regs;
        rd(ADDR_CUR_LIMIT, 8'h05);
        rd(ADDR_THR_HIGH, 8'hFF);
        rd(ADDR_THR_LOW, 8'hFF);
        rd(ADDR_RECOVERY, 8'h2A);
        rd(ADDR_SUCCESS_CUR, 8'h0F);
        rd(ADDR_SWITCH_CFG, 8'h14);
        rd(8'h30, 8'h00);
        wr(ADDR_CUR_LIMIT, 8'h07);
        rd(ADDR_CUR_LIMIT, 8'h05);
        wr(ADDR_CUR_LIMIT, 8'h02);
        rd(ADDR_CUR_LIMIT, 8'h02);
        chk(8'(limSel), 8'h02);
    endtask
    // Data switch in detect and active states, each profile
    task automatic t_switch;
        pwr = PPE_PWR_DETECT;
        attach = 1'h1;
        wr(ADDR_SWITCH_CFG, 8'h12);
        cyc(2);
        chk(8'(close), 8'h01);
        attach = 1'h0;
        cyc(2);
        chk(8'(close), 8'h00);
        pwr = PPE_PWR_ACTIVE;
        wr(ADDR_SWITCH_CFG, 8'h14);
        emulate(PPE_PROF_CDP);
        chk(8'(close), 8'h01);
        wr(ADDR_SWITCH_CFG, 8'h18);
        emulate(PPE_PROF_CUSTOM);
        wr(ADDR_SWITCH_CFG, 8'h10);
        cyc(2);
        chk(8'(close), 8'h01);
        cyc(16);
        chk(8'(close), 8'h01);
        wr(ADDR_SWITCH_CFG, 8'h11);
        emulate(PPE_PROF_DCPLEG);
        chk(8'(close), 8'h00);
        cyc(20);
        chk(8'(close), 8'h01);
    endtask
    // Threshold flag set, then cleared
    task automatic t_reached_flag_a;
        chk(8'(flagA), 8'h00);
        wr(ADDR_THR_HIGH, 8'h00);
        wr(ADDR_THR_LOW, 8'h30);
        for (n = 0; n < 40 && flagA !== 1'h1; n++) cyc(1);
        chk(8'(flagA), 8'h01);
        wr(ADDR_THR_HIGH, 8'hFF);
        clr = 1'h1;
        cyc(1);
        clr = 1'h0;
        chk(8'(flagA), 8'h00);
    endtask
    // Sleep keeps all but the success threshold
    task automatic t_sleep;
        wr(ADDR_SUCCESS_CUR, 8'h03);
        wr(ADDR_RECOVERY, 8'h45);
        sleep = 1'h1;
        cyc(1);
        sleep = 1'h0;
        cyc(2);
        rd(ADDR_SUCCESS_CUR, 8'h0F);
        rd(ADDR_RECOVERY, 8'h45);
        rd(ADDR_THR_LOW, 8'h30);
        chk(8'(vSel), 8'h01);
    endtask
    // Retry code 4 then a 15 ms test, 10 cycles per ms
    task automatic t_recover;
        errIn = 1'h1;
        cyc(1);
        errIn = 1'h0;
        for (n = 0; n < 800 && rec.portPowerOn !== 1'h1; n++) cyc(1);
        chk(8'(n >= 338 && n <= 356), 8'h01);
        chk(8'(rec.useTestCurrent), 8'h01);
        for (n = 0; n < 400 && rec.portPowerOn !== 1'h0; n++) cyc(1);
        chk(8'(n >= 138 && n <= 156), 8'h01);
    endtask
    // Restart closes an open switch
    task automatic t_restart;
        wr(ADDR_SWITCH_CFG, 8'h10);
        emulate(PPE_PROF_DCPLEG);
        chk(8'(close), 8'h00);
        rstrt = 1'h1;
        cyc(1);
        rstrt = 1'h0;
        for (n = 0; n < 4 && close !== 1'h1; n++) cyc(1);
        chk(8'(close), 8'h01);
    endtask
    // Main sequence
    initial begin
        cyc(10);
        srst = 1'h0;
        cyc(1);
        t_regs();
        t_switch();
        t_reached_flag_a();
        t_sleep();
        t_recover();
        t_restart();
        give_verdict();
    end
endmodule
